// ---- bench/dac_serial_host_interface_asserts.sv ----
// Port-level checker for the serial command front end.
// Assumes the bench drives pins on REF_CLK edges.
`timescale 1ns/100ps
module dac_host_checker (
	input wire logic REF_CLK,
	input wire logic SRST,
	input wire logic PORT_TYPE_SELECT,
	input wire logic PROTOCOL_SELECT,
	input wire logic OUTPUT_LOAD_STROBE_N,
	input wire logic FRAME_SELECT_N,
	input wire logic SERIAL_CLK,
	input wire logic SERIAL_IN,
	input wire logic RESET_IN_N,
	input wire logic POWER_DOWN,
	input wire logic POWER_DOWN_RES_SEL,
	input wire logic SERIAL_OUT,
	input wire logic BUSY_N,
	input wire logic OUTPUT_FLOAT,
	input wire logic OUTPUT_PULLDOWN,
	input wire logic LOW_POWER,
	input wire logic DAC_UPDATE
);
	default clocking cb @(posedge REF_CLK); endclocking
	logic [5:0] fall_cnt_r;
	logic       sclk_d_r;
	logic       rw_r;
	always_ff @(posedge REF_CLK) begin
		sclk_d_r <= SERIAL_CLK;
	end
	// Read frames start no calculation
	always_ff @(posedge REF_CLK) begin
		if (sclk_d_r && !SERIAL_CLK && fall_cnt_r == 6'h01) begin
			rw_r <= SERIAL_IN;
		end
	end
	// Saturates so long chains cannot wrap into a false full count
	always_ff @(posedge REF_CLK) begin
		if (SRST || FRAME_SELECT_N) begin
			fall_cnt_r <= 6'h00;
		end else if (sclk_d_r && !SERIAL_CLK && fall_cnt_r != 6'h3F) begin
			fall_cnt_r <= fall_cnt_r + 6'h01;
		end
	end
	AST_NO_UPD_BUSY: assert property (disable iff (SRST)
		DAC_UPDATE |-> BUSY_N) else $error("update while busy");
	AST_RST_STATE: assert property (SRST ##1 !SRST
		|-> !BUSY_N && OUTPUT_FLOAT) else $error("reset state wrong");
	AST_FRAME_BUSY: assert property (disable iff (SRST)
		$rose(FRAME_SELECT_N) && fall_cnt_r == 6'h18 && BUSY_N
		&& PORT_TYPE_SELECT && !PROTOCOL_SELECT && !rw_r
		|-> ##[1:8] !BUSY_N)
		else $error("no busy after frame");
	AST_SHORT_DROP: assert property (disable iff (SRST)
		$rose(FRAME_SELECT_N) && fall_cnt_r < 6'h18 && BUSY_N
		|=> BUSY_N [*8]) else $error("short frame taken");
	AST_HELD_LOAD: assert property (disable iff (SRST)
		$rose(BUSY_N) && !OUTPUT_LOAD_STROBE_N |-> ##[0:3] DAC_UPDATE)
		else $error("held strobe gave no update");
	AST_PWR_DOWN: assert property (disable iff (SRST)
		(POWER_DOWN && $stable(POWER_DOWN_RES_SEL)) [*4] |-> LOW_POWER
		&& OUTPUT_PULLDOWN == POWER_DOWN_RES_SEL
		&& OUTPUT_FLOAT != POWER_DOWN_RES_SEL)
		else $error("power-down outputs wrong");
	AST_PIN_RESET: assert property (disable iff (SRST)
		$fell(RESET_IN_N) |-> ##[1:6] !BUSY_N)
		else $error("reset pin gave no busy");
	AST_OUT_LAUNCH: assert property (disable iff (SRST)
		$changed(SERIAL_OUT) && !FRAME_SELECT_N |-> SERIAL_CLK)
		else $error("serial out moved on low clock");
endmodule : dac_host_checker
bind dac_serial_host_interface dac_host_checker chk (
	.REF_CLK(REF_CLK), .SRST(SRST), .PORT_TYPE_SELECT(PORT_TYPE_SELECT),
	.PROTOCOL_SELECT(PROTOCOL_SELECT), .SERIAL_CLK(SERIAL_CLK),
	.SERIAL_IN(SERIAL_IN),
	.OUTPUT_LOAD_STROBE_N(OUTPUT_LOAD_STROBE_N), .BUSY_N(BUSY_N),
	.FRAME_SELECT_N(FRAME_SELECT_N), .RESET_IN_N(RESET_IN_N),
	.POWER_DOWN(POWER_DOWN), .POWER_DOWN_RES_SEL(POWER_DOWN_RES_SEL),
	.SERIAL_OUT(SERIAL_OUT), .OUTPUT_FLOAT(OUTPUT_FLOAT),
	.OUTPUT_PULLDOWN(OUTPUT_PULLDOWN), .LOW_POWER(LOW_POWER),
	.DAC_UPDATE(DAC_UPDATE));

// ---- bench/dac_serial_host_interface_tb.sv ----
// Self-checking bench for the serial command front end.
// Assumes the host model owns the serial pins.
`timescale 1ns/100ps
`define CHECK(g, e) begin tests_run++; if ((g) !== (e)) begin \
	errors++; $display("unexpected at %0t: value mismatch", $time); end end
module dac_serial_host_interface_tb;
	import dac_host_pkg::*;
	logic        ref_clk, srst, port_type, chain_en, queue_en, pwr_dn;
	logic        pd_sel, rst_n, load_n, wr_n, sel_n;
	logic [5:0]  par_addr, last_ch;
	logic [11:0] par_data, last_val;
	logic [47:0] rd;
	logic        fs_n, sclk, sdi, serial_out, busy_n, flt, pull, lowp, upd;
	logic [5:0]  dac_ch;
	logic [11:0] dac_val;
	int          errors, tests_run, upd_cnt, n;
	dac_serial_host_interface #(.QDEPTH(16), .RESET_CYCLES(50)) dut (
		.REF_CLK(ref_clk), .SRST(srst), .PORT_TYPE_SELECT(port_type),
		.PROTOCOL_SELECT(1'b0), .CHAIN_ENABLE(chain_en),
		.TOGGLE_ENABLE(1'b0), .QUEUE_ENABLE(queue_en), .POWER_DOWN(pwr_dn),
		.POWER_DOWN_RES_SEL(pd_sel), .RESET_IN_N(rst_n),
		.CLEAR_INPUT_N(1'b1), .OUTPUT_LOAD_STROBE_N(load_n),
		.FRAME_SELECT_N(fs_n), .SERIAL_CLK(sclk), .SERIAL_IN(sdi),
		.SERIAL_OUT(serial_out), .PAR_WRITE_N(wr_n), .PAR_SELECT_N(sel_n),
		.PAR_CHANNEL_ADDRESS(par_addr), .PAR_TARGET_SELECT(TSEL_DATA),
		.PAR_DATA_WORD(par_data), .BUSY_N(busy_n), .OUTPUT_FLOAT(flt),
		.OUTPUT_PULLDOWN(pull), .LOW_POWER(lowp), .DAC_UPDATE(upd),
		.DAC_CHANNEL(dac_ch), .DAC_VALUE(dac_val));
	host_serial_model host (.clk(ref_clk), .serial_out(serial_out), .fs_n(fs_n),
		.sclk(sclk), .sdi(sdi));
	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		if (upd === 1'b1) begin
			upd_cnt++;
			last_ch = dac_ch;
			last_val = dac_val;
		end
	end
	function automatic logic [23:0] cmd(logic r, logic [5:0] c,
		logic [11:0] v);
		return {1'b0, r, c, TSEL_DATA, v, 2'h0};
	endfunction : cmd
	task automatic summarize();
		$display("errors %0d tests_run %0d", errors, tests_run);
		if (errors == 0 && tests_run > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : summarize
	task automatic wait_busy(input logic lvl);
		int i;
		for (i = 0; i < 400 && busy_n !== lvl; i++) @(posedge ref_clk);
		`CHECK(busy_n, lvl)
	endtask : wait_busy
	task automatic strobe(input int hold);
		load_n <= 1'b0;
		repeat (hold) @(posedge ref_clk);
		load_n <= 1'b1;
		repeat (6) @(posedge ref_clk);
	endtask : strobe
	task automatic send(input logic [23:0] w);
		host.frame({24'h000000, w}, 24, rd);
	endtask : send
	task automatic readback(input logic [5:0] c);
		send(cmd(1'b1, c, 12'h000));
		send(24'h000000);
		// The no-op frame writes channel 0; flush it before later loads
		wait_busy(1'b1);
		strobe(6);
	endtask : readback
	// Pins pass a 2FF synchroniser, so each phase lasts 3 clocks
	task automatic par_write(input logic [5:0] a, input logic [11:0] d);
		sel_n <= 1'b0;
		par_addr <= a;
		par_data <= d;
		wr_n <= 1'b0;
		repeat (3) @(posedge ref_clk);
		wr_n <= 1'b1;
		repeat (3) @(posedge ref_clk);
		sel_n <= 1'b1;
		@(posedge ref_clk);
	endtask : par_write
	initial begin
		#2000000;
		errors++;
		summarize();
	end
	initial begin
		{srst, port_type, rst_n, load_n, wr_n, sel_n} = 6'h3F;
		{chain_en, queue_en, pwr_dn, pd_sel} = 4'h0;
		{par_addr, par_data} = 18'h00000;
		errors = 0;
		tests_run = 0;
		upd_cnt = 0;
		repeat (4) @(posedge ref_clk);
		srst <= 1'b0;
		@(posedge ref_clk);
		#1 `CHECK(busy_n, 1'b0)
		`CHECK(flt, 1'b1)
		wait_busy(1'b1);
		n = upd_cnt;
		send(cmd(1'b0, 6'h05, 12'hA5C));
		wait_busy(1'b0);
		wait_busy(1'b1);
		`CHECK(upd_cnt, n)
		strobe(6);
		`CHECK(upd_cnt, n + 1)
		`CHECK(last_ch, 6'h05)
		`CHECK(last_val, 12'hA5C)
		strobe(6);
		`CHECK(upd_cnt, n + 1)
		send(cmd(1'b0, 6'h07, 12'h123));
		wait_busy(1'b0);
		strobe(2);
		`CHECK(upd_cnt, n + 1)
		wait_busy(1'b1);
		repeat (4) @(posedge ref_clk);
		`CHECK(last_ch, 6'h07)
		load_n <= 1'b0;
		send(cmd(1'b0, 6'h09, 12'hFFF));
		wait_busy(1'b0);
		wait_busy(1'b1);
		repeat (4) @(posedge ref_clk);
		`CHECK(last_val, 12'hFFF)
		load_n <= 1'b1;
		host.frame({28'h0000000, 20'hABCDE}, 20, rd);
		`CHECK(busy_n, 1'b1)
		readback(6'h09);
		`CHECK(rd[23:0], cmd(1'b1, 6'h09, 12'hFFF))
		`CHECK(last_ch, 6'h00)
		chain_en <= 1'b1;
		host.frame({cmd(1'b0, 6'h03, 12'h111), cmd(1'b0, 6'h04, 12'h222)},
			48, rd);
		`CHECK(rd[23:0], cmd(1'b0, 6'h03, 12'h111))
		wait_busy(1'b1);
		strobe(6);
		`CHECK(last_ch, 6'h04)
		chain_en <= 1'b0;
		pwr_dn <= 1'b1;
		pd_sel <= 1'b1;
		repeat (8) @(posedge ref_clk);
		`CHECK(pull, 1'b1)
		pd_sel <= 1'b0;
		repeat (8) @(posedge ref_clk);
		`CHECK({lowp, flt}, 2'h3)
		pwr_dn <= 1'b0;
		readback(6'h09);
		`CHECK(rd[13:2], 12'hFFF)
		port_type <= 1'b0;
		send(cmd(1'b0, 6'h01, 12'h001));
		`CHECK(busy_n, 1'b1)
		par_write(6'h02, 12'h0F0);
		wait_busy(1'b0);
		wait_busy(1'b1);
		strobe(6);
		`CHECK(last_val, 12'h0F0)
		queue_en <= 1'b1;
		rst_n <= 1'b0;
		repeat (8) @(posedge ref_clk);
		`CHECK(busy_n, 1'b0)
		rst_n <= 1'b1;
		n = upd_cnt;
		strobe(2);
		wait_busy(1'b1);
		`CHECK(upd_cnt, n)
		for (int c = 21; c < 29; c++) par_write(6'(c), 12'h800);
		`CHECK(busy_n, 1'b0)
		wait_busy(1'b1);
		strobe(6);
		`CHECK(last_ch, 6'h15)
		summarize();
	end
endmodule : dac_serial_host_interface_tb

// ---- bench/host_serial_model.sv ----
// Host serial master: frame select, gated serial clock, data out.
// Assumes it is driven from the bench clock; serial period 8 clocks.
`timescale 1ns/100ps
module host_serial_model (
	input  wire logic clk,
	input  wire logic serial_out,
	output logic      fs_n,
	output logic      sclk,
	output logic      sdi
);
	initial begin
		fs_n = 1'b1;
		sclk = 1'b1;
		sdi  = 1'b0;
	end
	// Exact clock count per frame; clock idles high between frames
	task automatic frame(input logic [47:0] w, input int n,
		output logic [47:0] rd);
		int i;
		rd = '0;
		@(posedge clk) fs_n <= 1'b0;
		for (i = n - 1; i >= 0; i--) begin
			sdi <= w[i];
			repeat (4) @(posedge clk);
			rd = {rd[46:0], serial_out};
			sclk <= 1'b0;
			repeat (4) @(posedge clk);
			sclk <= 1'b1;
		end
		repeat (4) @(posedge clk);
		fs_n <= 1'b1;
		// Released line shows the inverse, not a stale bit
		sdi  <= ~w[0];
		repeat (8) @(posedge clk);
	endtask : frame
endmodule : host_serial_model

// ---- design/cmd_fifo.sv ----
// Parameterised valid/ready command FIFO.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/100ps
module cmd_fifo #(
	parameter int WIDTH = 21,
	parameter int DEPTH = 16
) (
	input  wire logic             clk,
	input  wire logic             srst,
	input  wire logic [WIDTH-1:0] in_data,
	input  wire logic             in_valid,
	output logic                  in_ready,
	output logic      [WIDTH-1:0] out_data,
	output logic                  out_valid,
	input  wire logic             out_ready
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr_r;
	logic [AW-1:0]    rd_ptr_r;
	logic [AW:0]      count_r;
	logic             push;
	logic             pop;

	assign in_ready  = (count_r != (AW+1)'(DEPTH));
	assign out_valid = (count_r != '0);
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;
	assign out_data  = mem[rd_ptr_r];

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr_r] <= in_data;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r  <= '0;
		end else begin
			if (push) begin
				wr_ptr_r <= wr_ptr_r + 1'b1;
			end
			if (pop) begin
				rd_ptr_r <= rd_ptr_r + 1'b1;
			end
			if (push && !pop) begin
				count_r <= count_r + 1'b1;
			end else if (pop && !push) begin
				count_r <= count_r - 1'b1;
			end
		end
	end
endmodule : cmd_fifo

// ---- design/dac_host_pkg.sv ----
// Constants shared by the serial command front end and its helpers.
// Assumes a single 40 MHz reference clock.
package dac_host_pkg;
	localparam int FRAME_BITS      = 24;
	localparam int ADDR_BITS       = 6;
	localparam int DATA_BITS       = 12;
	localparam int QUEUE_DEPTH     = 128;
	localparam int CMD_BITS        = 21;
	// Frame bit positions, MSB first on the wire
	localparam int POS_BANK        = 23;
	localparam int POS_READ        = 22;
	localparam int POS_ADDR_HI     = 21;
	localparam int POS_ADDR_LO     = 16;
	localparam int POS_TSEL_HI     = 15;
	localparam int POS_TSEL_LO     = 14;
	localparam int POS_DATA_HI     = 13;
	localparam int POS_DATA_LO     = 2;
	// Command word layout: bank, target select, address, data
	localparam int CMD_BANK        = 20;
	localparam int CMD_TSEL_HI     = 19;
	localparam int CMD_TSEL_LO     = 18;
	localparam int CMD_ADDR_HI     = 17;
	localparam int CMD_ADDR_LO     = 12;
	// Timing
	localparam int CLK_PERIOD_PS   = 25000;
	localparam int CALC_TIME_NS    = 500;
	localparam int CALC_CYCLES     =
		(CALC_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int RESET_TIME_US   = 270;
	localparam int RESET_CYCLES    =
		(RESET_TIME_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam logic [1:0] TSEL_DATA = 2'h3;
endpackage : dac_host_pkg

// ---- design/dac_serial_host_interface.sv ----
// Command front end of a multi-channel DAC: serial port, parallel
// write queue, busy and output-load handling, reset and power-down.
// Assumes pins are asynchronous; serial clock far slower than REF_CLK.
// Behaviour
// (RULE_01) Any register write drives busy low while corrected data computes.
// (RULE_02) During busy writes still accepted; no DAC output update.
// (RULE_03) Load strobe during busy is remembered; applied once busy ends.
// (RULE_04) Strobe held low updates outputs every time busy returns high.
// (RULE_05) Busy low during reset; interfaces off, load strobes discarded.
// (RULE_06) Strobe copies only channels whose corrected data was rewritten.
// (RULE_07) Queue enable pin sampled at reset and clear; parallel mode only.
// (RULE_08) Queue holds up to 128 writes; busy low while draining; full drops.
// (RULE_09) Reset sets registers to defaults, outputs high impedance, busy low; regs and data_b are not reset here.
// (RULE_10) Power-down lowers power, outputs float or 100k, registers kept.
// (RULE_11) Port type selects parallel or serial; protocol pin picks wire count. Here protocol high turns the serial port off.
// (RULE_12) Three-wire port active with port type high and protocol low.
// (RULE_13) Frame 24 bits MSB first: bank, read, address, target, data, pad.
// (RULE_14) Bank bit selects data register A or B in toggle mode.
// (RULE_15) Standalone: falling select starts frame; clocks after 24 ignored.
// (RULE_16) Daisy chain: shifts while select low; overflow bits leave on output.
// (RULE_17) Host gives exactly 24 clocks per chained device.
// (RULE_18) Rising select latches the word and blocks further input bits.
// (RULE_19) Select rising before 24 clocks discards the frame.
// (RULE_20) Gated clock bursts exact count; free clock needs exact framing.
// (RULE_21) Read frame selects register; next frame returns address and data.
// (RULE_22) Readback bits launched on rising clock; first bit at select fall.
// (RULE_23) Serial input sampled on falling serial clock edge.
`timescale 1ns/100ps
module dac_serial_host_interface
	import dac_host_pkg::*;
#(
	parameter int NUM_CH       = 40,
	parameter int QDEPTH       = dac_host_pkg::QUEUE_DEPTH,
	parameter int RESET_CYCLES = dac_host_pkg::RESET_CYCLES
) (
	input  wire logic                               REF_CLK,
	input  wire logic                               SRST,
	input  wire logic                               PORT_TYPE_SELECT,
	input  wire logic                               PROTOCOL_SELECT,
	input  wire logic                               CHAIN_ENABLE,
	input  wire logic                               TOGGLE_ENABLE,
	input  wire logic                               QUEUE_ENABLE,
	input  wire logic                               POWER_DOWN,
	input  wire logic                               POWER_DOWN_RES_SEL,
	input  wire logic                               RESET_IN_N,
	input  wire logic                               CLEAR_INPUT_N,
	input  wire logic                               OUTPUT_LOAD_STROBE_N,
	input  wire logic                               FRAME_SELECT_N,
	input  wire logic                               SERIAL_CLK,
	input  wire logic                               SERIAL_IN,
	output logic                                    SERIAL_OUT,
	input  wire logic                               PAR_WRITE_N,
	input  wire logic                               PAR_SELECT_N,
	input  wire logic [dac_host_pkg::ADDR_BITS-1:0] PAR_CHANNEL_ADDRESS,
	input  wire logic [1:0]                         PAR_TARGET_SELECT,
	input  wire logic [dac_host_pkg::DATA_BITS-1:0] PAR_DATA_WORD,
	output logic                                    BUSY_N,
	output logic                                    OUTPUT_FLOAT,
	output logic                                    OUTPUT_PULLDOWN,
	output logic                                    LOW_POWER,
	output logic                                    DAC_UPDATE,
	output logic [dac_host_pkg::ADDR_BITS-1:0]      DAC_CHANNEL,
	output logic [dac_host_pkg::DATA_BITS-1:0]      DAC_VALUE
);
	import dac_host_pkg::*;

	localparam int CW = $clog2(RESET_CYCLES + 1);

	typedef enum logic [3:0] {
		ST_RESET = 4'h1,
		ST_IDLE  = 4'h2,
		ST_CALC  = 4'h4,
		ST_LOAD  = 4'h8
	} state_type;

	// Pin synchronisation
	logic [13:0] pins_s;
	sync_2ff #(
		.WIDTH(14)
	) u_sync (
		.clk(REF_CLK),
		.d  ({PORT_TYPE_SELECT, PROTOCOL_SELECT, CHAIN_ENABLE,
		      QUEUE_ENABLE, RESET_IN_N, CLEAR_INPUT_N,
		      OUTPUT_LOAD_STROBE_N, FRAME_SELECT_N, SERIAL_CLK,
		      SERIAL_IN, PAR_WRITE_N, POWER_DOWN,
		      POWER_DOWN_RES_SEL, TOGGLE_ENABLE}),
		.q  (pins_s)
	);
	logic ptype_s, proto_s, chain_s, qen_s, rst_n_s, clr_n_s;
	logic load_n_s, fs_n_s, sclk_s, sdi_s, wr_n_s;
	logic pd_s, pdsel_s, tog_s;
	assign {ptype_s, proto_s, chain_s, qen_s, rst_n_s, clr_n_s,
		load_n_s, fs_n_s, sclk_s, sdi_s, wr_n_s,
		pd_s, pdsel_s, tog_s} = pins_s;

	// Parallel address/data are stable around the write edge
	logic [ADDR_BITS-1:0] par_addr_r;
	logic [1:0]           par_tsel_r;
	logic [DATA_BITS-1:0] par_data_r;
	logic                 par_cs_r;
	always_ff @(posedge REF_CLK) begin
		par_addr_r <= PAR_CHANNEL_ADDRESS;
		par_tsel_r <= PAR_TARGET_SELECT;
		par_data_r <= PAR_DATA_WORD;
		par_cs_r   <= ~PAR_SELECT_N;
	end

	// Edge history
	logic rst_n_d_r, clr_n_d_r, fs_n_d_r, sclk_d_r, wr_n_d_r;
	logic load_n_d_r;
	always_ff @(posedge REF_CLK) begin
		load_n_d_r <= load_n_s;
		rst_n_d_r <= rst_n_s;
		clr_n_d_r <= clr_n_s;
		fs_n_d_r  <= fs_n_s;
		sclk_d_r  <= sclk_s;
		wr_n_d_r  <= wr_n_s;
	end
	logic rst_fall, clr_fall, fs_fall, fs_rise, sclk_fall, sclk_rise, wr_rise;
	assign rst_fall  = rst_n_d_r & ~rst_n_s;
	assign clr_fall  = clr_n_d_r & ~clr_n_s;
	assign fs_fall   = fs_n_d_r & ~fs_n_s;
	assign fs_rise   = ~fs_n_d_r & fs_n_s;
	assign sclk_fall = sclk_d_r & ~sclk_s;
	assign sclk_rise = ~sclk_d_r & sclk_s;
	assign wr_rise   = ~wr_n_d_r & wr_n_s;

	state_type      state_r;
	logic [CW-1:0]  timer_r;
	logic           ifc_on;
	logic           serial_on;
	logic           par_on;
	assign ifc_on    = (state_r != ST_RESET);
	assign par_on    = ifc_on & ~ptype_s; // RULE_11
	assign serial_on = ifc_on & ptype_s & ~proto_s; // RULE_11 RULE_12

	// Queue mode latched at reset and at clear
	logic queue_mode_r;
	always_ff @(posedge REF_CLK) begin
		if (SRST || rst_fall || clr_fall) begin
			queue_mode_r <= qen_s; // RULE_07
		end
	end

	// Serial frame reception
	logic [FRAME_BITS-1:0] shift_r;
	logic [4:0]            bit_cnt_r;
	logic                  in_frame_r;
	logic                  frame_full;
	logic                  serial_done;
	logic                  readback_req_r;
	logic [FRAME_BITS-1:0] readback_word_r;
	assign frame_full = (bit_cnt_r == 5'(FRAME_BITS));

	always_ff @(posedge REF_CLK) begin
		if (SRST || !serial_on) begin
			in_frame_r <= 1'b0;
			bit_cnt_r  <= '0;
		end else if (fs_fall) begin
			in_frame_r <= 1'b1; // RULE_15
			bit_cnt_r  <= '0;
		end else if (fs_rise) begin
			in_frame_r <= 1'b0; // RULE_18
		end else if (in_frame_r && sclk_fall) begin
			if (!frame_full) begin
				bit_cnt_r <= bit_cnt_r + 5'h01;
			end
		end
	end

	// Chain mode keeps shifting past 24; standalone stops there
	always_ff @(posedge REF_CLK) begin
		if (SRST) begin
			shift_r <= '0;
		end else if (serial_on && fs_fall && readback_req_r) begin
			shift_r <= readback_word_r; // RULE_21
		end else if (in_frame_r && !fs_rise && sclk_fall &&
			(chain_s || !frame_full)) begin // RULE_15 RULE_16
			shift_r <= {shift_r[FRAME_BITS-2:0], sdi_s}; // RULE_23 RULE_13
		end
	end

	// Output bit launched on rising serial clock, first bit at frame start
	always_ff @(posedge REF_CLK) begin
		if (SRST) begin
			SERIAL_OUT <= 1'b0;
		end else if (serial_on && fs_fall && readback_req_r) begin
			SERIAL_OUT <= readback_word_r[FRAME_BITS-1]; // RULE_22
		end else if (in_frame_r && sclk_rise) begin
			SERIAL_OUT <= shift_r[FRAME_BITS-1]; // RULE_16 RULE_22
		end
	end

	// Short frames are discarded
	assign serial_done = in_frame_r & fs_rise & frame_full; // RULE_19

	// Command sources
	logic [CMD_BITS-1:0] ser_cmd;
	logic [CMD_BITS-1:0] par_cmd;
	logic                ser_write;
	logic                par_write;
	assign ser_cmd = {shift_r[POS_BANK] & tog_s, // RULE_14
		shift_r[POS_TSEL_HI:POS_TSEL_LO],
		shift_r[POS_ADDR_HI:POS_ADDR_LO],
		shift_r[POS_DATA_HI:POS_DATA_LO]};
	assign par_cmd   = {1'b0, par_tsel_r, par_addr_r, par_data_r};
	assign ser_write = serial_done & ~shift_r[POS_READ];
	assign par_write = par_on & par_cs_r & wr_rise;

	// Register storage
	logic [DATA_BITS-1:0] regs [4][NUM_CH];
	logic [DATA_BITS-1:0] data_b [NUM_CH];
	logic [NUM_CH-1:0]    dirty_r;

	always_ff @(posedge REF_CLK) begin
		if (SRST || rst_fall) begin
			readback_req_r  <= 1'b0;
			readback_word_r <= '0;
		end else if (serial_done && shift_r[POS_READ]) begin
			readback_req_r  <= 1'b1;
			readback_word_r <= {shift_r[POS_BANK:POS_TSEL_LO],
				regs[shift_r[POS_TSEL_HI:POS_TSEL_LO]]
				[shift_r[POS_ADDR_HI:POS_ADDR_LO]], 2'h0};
		end else if (serial_on && fs_fall) begin
			readback_req_r <= 1'b0;
		end
	end

	// Queue between the ports and the calculation engine
	logic [CMD_BITS-1:0] q_in;
	logic                q_in_valid;
	logic                q_in_ready;
	logic [CMD_BITS-1:0] q_out;
	logic                q_out_valid;
	logic                q_out_ready;
	assign q_in       = par_write ? par_cmd : ser_cmd;
	// Without the queue, one entry at a time behaves as a plain latch
	assign q_in_valid = (par_write &
		(queue_mode_r | ~q_out_valid)) | ser_write; // RULE_08 RULE_02
	assign q_out_ready = (state_r == ST_IDLE);

	cmd_fifo #(
		.WIDTH(CMD_BITS),
		.DEPTH(QDEPTH)
	) u_queue (
		.clk      (REF_CLK),
		.srst     (SRST | rst_fall),
		.in_data  (q_in),
		.in_valid (q_in_valid),
		.in_ready (q_in_ready), // RULE_08
		.out_data (q_out),
		.out_valid(q_out_valid),
		.out_ready(q_out_ready)
	);

	// Edge remembered, level acts directly; a stale pend would replay
	logic load_pend_r;
	logic load_req;
	logic load_fall;
	assign load_req  = ~load_n_s; // RULE_04
	assign load_fall = load_n_d_r & ~load_n_s;
	always_ff @(posedge REF_CLK) begin
		if (SRST || state_r == ST_RESET) begin
			load_pend_r <= 1'b0; // RULE_05
		end else if (load_fall) begin
			load_pend_r <= 1'b1; // RULE_03
		end else if (state_r == ST_LOAD) begin
			load_pend_r <= 1'b0;
		end
	end

	// Control sequencer
	logic [CMD_BITS-1:0] cur_r;
	logic [NUM_CH-1:0]   load_ch;
	always_ff @(posedge REF_CLK) begin
		if (SRST || rst_fall) begin
			state_r <= ST_RESET; // RULE_05 RULE_09
			timer_r <= CW'(RESET_CYCLES - 1);
			cur_r   <= '0;
		end else begin
			case (state_r)
				ST_RESET: begin
					if (timer_r == '0) begin
						state_r <= ST_IDLE;
					end else begin
						timer_r <= timer_r - 1'b1;
					end
				end
				ST_IDLE: begin
					if (q_out_valid) begin
						cur_r   <= q_out;
						timer_r <= CW'(CALC_CYCLES - 1);
						state_r <= ST_CALC; // RULE_01
					end else if ((load_pend_r || load_req) &&
						dirty_r != '0) begin
						state_r <= ST_LOAD; // RULE_03 RULE_06
					end
				end
				ST_CALC: begin
					if (timer_r == '0) begin
						state_r <= ST_IDLE;
					end else begin
						timer_r <= timer_r - 1'b1;
					end
				end
				ST_LOAD: state_r <= ST_IDLE;
				default: state_r <= ST_RESET;
			endcase
		end
	end

	// Busy spans reset, calculation and queued entries
	assign BUSY_N = (state_r == ST_IDLE) & ~q_out_valid
		| (state_r == ST_LOAD); // RULE_01 RULE_08

	// Register write at end of calculation; corrected data marked dirty
	logic                 calc_end;
	logic [ADDR_BITS-1:0] cur_ch;
	assign calc_end = (state_r == ST_CALC) && (timer_r == '0);
	assign cur_ch   = cur_r[CMD_ADDR_HI:CMD_ADDR_LO];
	always_ff @(posedge REF_CLK) begin
		if (calc_end && cur_ch < ADDR_BITS'(NUM_CH)) begin
			if (cur_r[CMD_TSEL_HI:CMD_TSEL_LO] == TSEL_DATA &&
				cur_r[CMD_BANK]) begin
				data_b[cur_ch] <= cur_r[DATA_BITS-1:0]; // RULE_14
			end else begin
				regs[cur_r[CMD_TSEL_HI:CMD_TSEL_LO]][cur_ch]
					<= cur_r[DATA_BITS-1:0];
			end
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (SRST || rst_fall) begin
			dirty_r <= '0;
		end else if (state_r == ST_LOAD) begin
			dirty_r <= '0; // RULE_06
		end else if (calc_end && cur_ch < ADDR_BITS'(NUM_CH)) begin
			dirty_r[cur_ch] <= 1'b1;
		end
	end

	// Single-channel update report: lowest dirty channel each load
	always_comb begin
		load_ch = dirty_r & (~dirty_r + 1'b1);
	end
	logic [ADDR_BITS-1:0] first_ch;
	always_comb begin
		first_ch = '0;
		for (int i = NUM_CH - 1; i >= 0; i--) begin
			if (dirty_r[i]) begin
				first_ch = ADDR_BITS'(i);
			end
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (SRST || rst_fall) begin
			DAC_UPDATE  <= 1'b0;
			DAC_CHANNEL <= '0;
			DAC_VALUE   <= '0;
		end else begin
			DAC_UPDATE <= (state_r == ST_LOAD); // RULE_02 RULE_06
			if (state_r == ST_LOAD) begin
				DAC_CHANNEL <= first_ch;
				DAC_VALUE   <= regs[TSEL_DATA][first_ch];
			end
		end
	end

	// Power-down: registers untouched, only LOW_POWER and output drive change
	always_ff @(posedge REF_CLK) begin
		if (SRST) begin
			LOW_POWER       <= 1'b0;
			OUTPUT_FLOAT    <= 1'b1; // RULE_09
			OUTPUT_PULLDOWN <= 1'b0;
		end else begin
			LOW_POWER       <= pd_s; // RULE_10
			OUTPUT_FLOAT    <= (state_r == ST_RESET) |
				(pd_s & ~pdsel_s);
			OUTPUT_PULLDOWN <= pd_s & pdsel_s;
		end
	end
endmodule : dac_serial_host_interface

// ---- design/sync_2ff.sv ----
// Two flip-flop synchroniser for a bus of level signals.
// Assumes inputs are asynchronous to clk.
`timescale 1ns/100ps
module sync_2ff #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk,
	input  wire logic [WIDTH-1:0] d,
	output logic      [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta_r;

	always_ff @(posedge clk) begin
		meta_r <= d;
		q      <= meta_r;
	end
endmodule : sync_2ff
